//--- logic/cmc_consts.vh
// Constants for the processor clock and operating-mode control block
// Operation
// RULE_01 - The block holds a 4-bit processor clock control register that picks the CPU clock rate and the operating mode.
// RULE_02 - Reset clears that register to 0000, so the CPU starts on the slowest clock (fxx/64, 15.3 us at 4.19 MHz).
// RULE_03 - Standby is in force whenever bit 3 or bit 2 of the register is one.
// RULE_04 - The standby release signal clears both standby bits and returns the CPU to normal operation.
// RULE_05 - The STOP instruction sets bit 3 and the HALT instruction sets bit 2.
// RULE_06 - Software writes the two clock-select bits only with a 4-bit write that holds both standby bits at zero.
// RULE_07 - Select code 0011 gives the fastest CPU clock, fxx/4, a 0.95 us machine cycle at 4.19 MHz.
// RULE_08 - Select code 0010 gives the intermediate CPU clock, fxx/8, 1.63 us at 4.91 MHz.
// RULE_09 - Above 4.19 MHz and up to 5.0 MHz software uses only codes 00 and 10, never 11.
// RULE_10 - Exactly three CPU clock rates are offered, all from the same system clock.
// RULE_11 - After a select change the old rate lasts up to 1, 8 or 16 machine cycles when leaving 0000, 0010 or 0011.
// RULE_12 - One period of the selected CPU clock is one machine cycle, the shortest instruction time.
// RULE_13 - Peripherals receive clocks divided down from the system clock.
// RULE_14 - Software never selects STOP when an external clock drives the system.
// RULE_15 - In STOP the oscillator input pin is tied to ground internally and oscillation stops.
// RULE_16 - Software places a no-operation instruction right after every STOP or HALT.
// RULE_17 - The CPU clock divider switches only on a machine-cycle boundary so no short pulse reaches the CPU.
`ifndef CMC_CONSTS_VH
`define CMC_CONSTS_VH

`define CMC_REG_W 4
`define CMC_PCC_RESET 4'h0
`define CMC_BIT_STOP 3
`define CMC_BIT_HALT 2
`define CMC_SEL_HI 1
`define CMC_SEL_LO 0

`define CMC_SEL_SLOW 2'h0
`define CMC_SEL_MID 2'h2
`define CMC_SEL_FAST 2'h3

// Prescaler tap index n gives a pulse every 2^(n+1) system clocks
`define CMC_PRE_W 9
`define CMC_TAP_SLOW 4'h5
`define CMC_TAP_MID 4'h2
`define CMC_TAP_FAST 4'h1

// Old-rate machine cycles before a new select takes effect
`define CMC_WAIT_W 5
`define CMC_WAIT_SLOW 5'h01
`define CMC_WAIT_MID 5'h08
`define CMC_WAIT_FAST 5'h10

`endif

//--- logic/cmc_prescaler.v
// System clock prescaler, held while run_in is low, with one pulse tap per power of two
`timescale 1ns/10ps
`include "cmc_consts.vh"

module cmc_prescaler (
	input wire clk_in,
	input wire rstn_in,
	input wire run_in,
	output wire [`CMC_PRE_W-1:0] tick_out
);
	reg [`CMC_PRE_W-1:0] cnt_q;
	wire [`CMC_PRE_W-1:0] cnt_d;

	assign cnt_d = run_in ? cnt_q + {{(`CMC_PRE_W-1){1'b0}}, 1'b1} : cnt_q;

	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cnt_q <= {`CMC_PRE_W{1'b0}};
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// Tap n fires when the low n+1 bits are all ones
	genvar n;
	generate
		for (n = 0; n < `CMC_PRE_W; n = n + 1) begin : g_tap
			assign tick_out[n] = run_in & (&cnt_q[n:0]);
		end
	endgenerate
endmodule // cmc_prescaler

//--- logic/cmc_clock_ctrl.v
// Processor clock control register, CPU clock selection and standby control
`timescale 1ns/10ps
`include "cmc_consts.vh"

module cmc_clock_ctrl (
	input wire CORE_CLK_IN,
	input wire RSTN_IN,
	input wire PCC_WR_IN,
	input wire [3:0] PCC_WDATA_IN,
	input wire STOP_EXEC_IN,
	input wire HALT_EXEC_IN,
	input wire STANDBY_RELEASE_IN,
	output wire [3:0] PCC_RDATA_OUT,
	output wire CPU_CLK_EN_OUT,
	output wire STANDBY_OUT,
	output wire STOP_MODE_OUT,
	output wire HALT_MODE_OUT,
	output wire [1:0] ACTIVE_SEL_OUT,
	output wire SWITCH_PENDING_OUT,
	output wire [8:0] PERIPH_CLK_EN_OUT,
	output wire OSC_IN_PIN_OUT,
	output wire OSC_IN_PIN_OE_OUT
);
	// Map a select code to its prescaler tap; 01 is unused and runs slow
	function [3:0] sel_tap;
		input [1:0] sel;
		begin
			case (sel)
				`CMC_SEL_FAST: sel_tap = `CMC_TAP_FAST;
				`CMC_SEL_MID: sel_tap = `CMC_TAP_MID;
				default: sel_tap = `CMC_TAP_SLOW;
			endcase
		end
	endfunction

	// Old-rate cycles to run out when leaving a select code
	function [`CMC_WAIT_W-1:0] sel_wait;
		input [1:0] sel;
		begin
			case (sel)
				`CMC_SEL_FAST: sel_wait = `CMC_WAIT_FAST;
				`CMC_SEL_MID: sel_wait = `CMC_WAIT_MID;
				default: sel_wait = `CMC_WAIT_SLOW;
			endcase
		end
	endfunction

	reg [3:0] pcc_q;
	reg [3:0] pcc_d;
	reg [1:0] active_sel_q;
	reg [1:0] active_sel_d;
	reg [`CMC_WAIT_W-1:0] wait_q;
	reg [`CMC_WAIT_W-1:0] wait_d;
	reg pending_q;
	reg pending_d;
	reg phi_q;
	reg [8:0] periph_q;
	wire [`CMC_PRE_W-1:0] tick;
	wire phi_tick;
	wire stop_mode;
	wire halt_mode;
	wire standby;

	assign stop_mode = pcc_q[`CMC_BIT_STOP];
	assign halt_mode = pcc_q[`CMC_BIT_HALT];
	assign standby = stop_mode | halt_mode; // RULE_03

	// Oscillation stops in STOP, so the whole prescaler freezes
	cmc_prescaler u_pre (
		.clk_in(CORE_CLK_IN),
		.rstn_in(RSTN_IN),
		.run_in(~stop_mode), // RULE_15
		.tick_out(tick)
	);

	// One tap per machine cycle of the active rate, all from one counter
	assign phi_tick = tick[sel_tap(active_sel_q)]; // RULE_10 RULE_12

	// Control register: write, instruction sets and standby release
	always @* begin
		pcc_d = pcc_q;
		if (PCC_WR_IN) begin
			pcc_d = PCC_WDATA_IN; // RULE_01 RULE_06
		end
		if (STANDBY_RELEASE_IN) begin
			pcc_d[`CMC_BIT_STOP] = 1'b0; // RULE_04
			pcc_d[`CMC_BIT_HALT] = 1'b0; // RULE_04
		end
		// Set wins over a release in the same cycle
		if (STOP_EXEC_IN) begin
			pcc_d[`CMC_BIT_STOP] = 1'b1; // RULE_05
		end
		if (HALT_EXEC_IN) begin
			pcc_d[`CMC_BIT_HALT] = 1'b1; // RULE_05
		end
	end

	// Delayed switch-over, counted in old-rate machine cycles
	always @* begin
		active_sel_d = active_sel_q;
		wait_d = wait_q;
		pending_d = pending_q;
		if (pending_q && phi_tick) begin
			if (wait_q == {{(`CMC_WAIT_W-1){1'b0}}, 1'b1}) begin
				active_sel_d = pcc_q[1:0]; // RULE_17 RULE_07 RULE_08
				pending_d = 1'b0;
			end else begin
				wait_d = wait_q - {{(`CMC_WAIT_W-1){1'b0}}, 1'b1}; // RULE_11
			end
		end
		if (PCC_WR_IN && !pending_q && PCC_WDATA_IN[1:0] != active_sel_q) begin
			wait_d = sel_wait(active_sel_q); // RULE_11
			pending_d = 1'b1;
		end
		// Rewriting the active code cancels a pending change
		if (PCC_WR_IN && pending_q && PCC_WDATA_IN[1:0] == active_sel_q) begin
			pending_d = 1'b0;
		end
	end

	always @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			pcc_q <= `CMC_PCC_RESET; // RULE_02
			active_sel_q <= `CMC_SEL_SLOW; // RULE_02
			wait_q <= {`CMC_WAIT_W{1'b0}};
			pending_q <= 1'b0;
			phi_q <= 1'b0;
			periph_q <= 9'h000;
		end else begin
			pcc_q <= pcc_d;
			active_sel_q <= active_sel_d;
			wait_q <= wait_d;
			pending_q <= pending_d;
			phi_q <= phi_tick & ~standby; // RULE_03 RULE_12
			periph_q <= tick; // RULE_13
		end
	end

	assign PCC_RDATA_OUT = pcc_q;
	assign CPU_CLK_EN_OUT = phi_q;
	assign STANDBY_OUT = standby;
	assign STOP_MODE_OUT = stop_mode;
	assign HALT_MODE_OUT = halt_mode;
	assign ACTIVE_SEL_OUT = active_sel_q;
	assign SWITCH_PENDING_OUT = pending_q;
	assign PERIPH_CLK_EN_OUT = periph_q;
	// Oscillator input pulled to ground while stopped
	assign OSC_IN_PIN_OUT = 1'b0; // RULE_15
	assign OSC_IN_PIN_OE_OUT = stop_mode; // RULE_15
endmodule // cmc_clock_ctrl

//--- bench/cmc_clock_ctrl_assertions.sv
// Assertion checker for the processor clock control block
`timescale 1ns/10ps
module cmc_clock_ctrl_chk (
	input wire CORE_CLK_IN,
	input wire RSTN_IN,
	input wire PCC_WR_IN,
	input wire [3:0] PCC_WDATA_IN,
	input wire STOP_EXEC_IN,
	input wire HALT_EXEC_IN,
	input wire STANDBY_RELEASE_IN,
	input wire [3:0] PCC_RDATA_OUT,
	input wire CPU_CLK_EN_OUT,
	input wire STANDBY_OUT,
	input wire STOP_MODE_OUT,
	input wire HALT_MODE_OUT,
	input wire SWITCH_PENDING_OUT
);
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (!RSTN_IN);
	wire set_any = STOP_EXEC_IN | HALT_EXEC_IN;
	a_write_stores: assert property (PCC_WR_IN && !set_any && !STANDBY_RELEASE_IN
		|=> PCC_RDATA_OUT == $past(PCC_WDATA_IN)) else $error("write not stored");
	a_stby_level: assert property (STANDBY_OUT == |PCC_RDATA_OUT[3:2])
		else $error("standby level wrong");
	a_stop_sets: assert property (STOP_EXEC_IN |=> PCC_RDATA_OUT[3] && STOP_MODE_OUT)
		else $error("stop bit not set");
	a_halt_sets: assert property (HALT_EXEC_IN |=> PCC_RDATA_OUT[2] && HALT_MODE_OUT)
		else $error("halt bit not set");
	a_release_clears: assert property (STANDBY_RELEASE_IN && !set_any && !PCC_WR_IN
		|=> !STANDBY_OUT) else $error("standby not released");
	a_phi_gated: assert property (STANDBY_OUT && $past(STANDBY_OUT) |-> !CPU_CLK_EN_OUT)
		else $error("cpu clock runs in standby");
	a_fast_spacing: assert property (CPU_CLK_EN_OUT |=> !CPU_CLK_EN_OUT [*3])
		else $error("cpu clock pulses too close");
	a_switch_bound: assert property ($rose(SWITCH_PENDING_OUT) && !STANDBY_OUT
		|-> ##[1:140] !SWITCH_PENDING_OUT) else $error("clock switch too slow");
	cover property (STOP_MODE_OUT);
	cover property (HALT_MODE_OUT);
	cover property ($fell(SWITCH_PENDING_OUT));
endmodule // cmc_clock_ctrl_chk
bind cmc_clock_ctrl cmc_clock_ctrl_chk u_chk (.*);

//--- bench/cmc_cpu_model.sv
// CPU core model issuing register writes and standby instructions
`timescale 1ns/10ps
module cmc_cpu_model (
	input wire clk_in,
	output logic wr_out,
	output logic [3:0] wdata_out,
	output logic stop_out,
	output logic halt_out,
	output logic release_out
);
	initial {wr_out, wdata_out, stop_out, halt_out, release_out} = 8'h00;
	// One-cycle request: k picks write, stop, halt or release
	// Crystal source at nominal rate: STOP and code 11 both allowed
	task automatic issue(input logic [1:0] k, input logic [3:0] d);
		@(posedge clk_in);
		#1;
		wdata_out = d;
		{wr_out, stop_out, halt_out, release_out} = 4'h8 >> k;
		@(posedge clk_in);
		#1;
		{wr_out, stop_out, halt_out, release_out} = 4'h0;
		wdata_out = ~d;
	endtask
endmodule // cmc_cpu_model

//--- bench/tb_top.sv
// Self-checking bench for the processor clock control block
`timescale 1ns/10ps
module tb_top;
	logic CORE_CLK_IN = 1'b0;
	logic RSTN_IN = 1'b0;
	logic PCC_WR_IN, STOP_EXEC_IN, HALT_EXEC_IN, STANDBY_RELEASE_IN;
	logic [3:0] PCC_WDATA_IN, PCC_RDATA_OUT;
	logic CPU_CLK_EN_OUT, STANDBY_OUT, STOP_MODE_OUT, HALT_MODE_OUT;
	logic SWITCH_PENDING_OUT, OSC_IN_PIN_OUT, OSC_IN_PIN_OE_OUT;
	logic [1:0] ACTIVE_SEL_OUT;
	logic [8:0] PERIPH_CLK_EN_OUT;
	int n_fail = 0;
	int check_count = 0;
	always #2.5 CORE_CLK_IN = ~CORE_CLK_IN;
	cmc_cpu_model u_cpu (.clk_in(CORE_CLK_IN), .wr_out(PCC_WR_IN), .wdata_out(PCC_WDATA_IN),
		.stop_out(STOP_EXEC_IN), .halt_out(HALT_EXEC_IN), .release_out(STANDBY_RELEASE_IN));
	cmc_clock_ctrl u_dut (.*);
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic tick;
		@(posedge CORE_CLK_IN);
		#1;
	endtask
	// Clocks from one CPU clock pulse to the next
	task automatic span(output int n);
		n = 0;
		for (int i = 0; i < 400; i++) begin
			tick();
			if (CPU_CLK_EN_OUT && n > 0) return;
			if (CPU_CLK_EN_OUT || n > 0) n++;
		end
		chk(8'h01, 8'h00);
		report_and_stop();
	endtask
	// Peripheral tap 1 pulses once every 4 clocks
	task automatic periph;
		int n = 0;
		repeat (64) begin
			tick();
			n += PERIPH_CLK_EN_OUT[1];
		end
		chk(8'(n), 8'h10);
	endtask
	task automatic select(input logic [3:0] code, input logic [7:0] per);
		int w, p;
		u_cpu.issue(2'd0, code);
		chk(8'(PCC_RDATA_OUT), 8'(code));
		for (w = 0; w < 200 && SWITCH_PENDING_OUT !== 1'b0; w++) tick();
		chk(8'(w <= 66), 8'h01);
		chk(8'(ACTIVE_SEL_OUT), 8'(code));
		span(p);
		span(p);
		chk(8'(p), per);
	endtask
	task automatic standby(input logic [1:0] k, input logic [7:0] flags);
		int n = 0;
		u_cpu.issue(k, 4'h0);
		chk({PCC_RDATA_OUT, STANDBY_OUT, STOP_MODE_OUT, HALT_MODE_OUT, OSC_IN_PIN_OE_OUT}, flags);
		repeat (100) begin
			tick();
			n += CPU_CLK_EN_OUT;
		end
		chk(8'(n) | 8'(OSC_IN_PIN_OUT), 8'h00);
		u_cpu.issue(2'd3, 4'h0);
		chk({PCC_RDATA_OUT, STANDBY_OUT, STOP_MODE_OUT, HALT_MODE_OUT, OSC_IN_PIN_OE_OUT}, 8'h00);
		repeat (2) tick();
	endtask
	initial begin
		int p;
		repeat (3) tick();
		RSTN_IN = 1'b1;
		chk({PCC_RDATA_OUT, 2'h0, ACTIVE_SEL_OUT}, 8'h00);
		periph();
		span(p);
		chk(8'(p), 8'h40);
		select(4'h3, 8'h04);
		select(4'h2, 8'h08);
		select(4'h0, 8'h40);
		standby(2'd2, 8'h4A);
		standby(2'd1, 8'h8D);
		report_and_stop();
	end
endmodule // tb_top
